// File: inc/sdd_pkg.sv
// Operation
// RULE_01: sender keeps the service at or under 19.392656 Mbit/s by default
// RULE_02: a signalled peak bitrate counts transport packet overhead too
// RULE_03: stream type 0xC2 selects the synchronous model
// RULE_04: synchronous mode admits only PES bytes into the smoothing buffer
// RULE_05: duplicate packets never reach the smoothing buffer; transfer is instant
// RULE_06: sender keeps transport and smoothing buffers from overflowing
// RULE_07: first 16-bit unit of a stamped packet leaves at its stamp
// RULE_08: later units pace by increment below 9 Mbps, ES rate above
// RULE_09: bytes outside 16-bit units leave at once and are dropped
// RULE_10: unstamped packets leak at their own signalled rate
// RULE_11: signalled packet rate never exceeds the profile or descriptor rate
// RULE_12: sender carries clock references so stamps map onto the timeline
// RULE_13: stream types 0x06 and 0x14 select the synchronized model
// RULE_14: synchronized mode admits only PES and download section bytes
// RULE_15: PES unit runs from one stamped packet to the next stamped one
// RULE_16: section unit starts at stamped section 0, one module and version
// RULE_17: sender gives every access unit a distinct stamp
// RULE_18: PES and packet header bytes never enter the reassembly buffer
// RULE_19: only payload of table 0x3C sections enters; headers dropped
// RULE_20: checksum, message header and first 6 block bytes are dropped
// RULE_21: smoothing buffer drains at the leak rate while data and room exist
// RULE_22: draining stops when reassembly buffer is full or no data waits
// RULE_23: sender paces data so the reassembly buffer never overflows
// RULE_24: transport stage buffer holds 512 bytes
// RULE_25: without descriptor, leak is 19.2 Mbps and capacity 10000 bytes; the code leaks one byte per 9 cycles at 20 MHz, about 17.8 Mbps
// RULE_26: oldest complete unit leaves the reassembly buffer at its stamp
// RULE_27: reassembly buffer holds at least 120120 bytes
// RULE_28: sticky error on any overflow or unit incomplete at its stamp
package sdd_pkg;
	// timing
	localparam int unsigned CLK_HZ       = 20_000_000;
	localparam int unsigned DEF_LEAK_BPS = 19_200_000;
	localparam int unsigned SPLIT_BPS    = 9_000_000;
	localparam logic [15:0] LEAK_CYC_DEF = 16'((CLK_HZ * 8 + DEF_LEAK_BPS - 1) / DEF_LEAK_BPS);
	localparam logic [15:0] SPLIT_CYC    = 16'(CLK_HZ * 16 / SPLIT_BPS);
	// buffer sizes and layout
	localparam logic [9:0]  TB_BYTES  = 10'h200;
	localparam int          SB_AW     = 14;
	localparam int          SB_DEPTH  = 2 ** SB_AW;
	localparam logic [13:0] SB_BYTES  = 14'h2710;
	localparam logic [16:0] DEB_BYTES = 17'h1_D538;
	localparam int          MEM_W     = 10;
	localparam int          BIT_KEEP  = 8;
	localparam int          BIT_START = 9;
	localparam logic [2:0]  BLK_SKIP  = 3'h6;
	// stream and section codes
	localparam logic [7:0]  ST_SYNC    = 8'hC2;
	localparam logic [7:0]  ST_SYNCD_A = 8'h06;
	localparam logic [7:0]  ST_SYNCD_B = 8'h14;
	localparam logic [7:0]  TID_DL     = 8'h3C;
	// registers
	localparam logic [7:0]  REG_CTRL   = 8'h00;
	localparam logic [7:0]  REG_LEAK   = 8'h04;
	localparam logic [7:0]  REG_SBSIZE = 8'h08;
	localparam logic [7:0]  REG_STATUS = 8'h0C;
	localparam logic [7:0]  REG_DEBOCC = 8'h10;
	localparam logic [8:0]  CTRL_RST   = 9'h000;
	localparam int          CTRL_DESC  = 8;
	localparam int          ERR_TB     = 0;
	localparam int          ERR_SB     = 1;
	localparam int          ERR_RING   = 2;
	localparam int          ERR_UNDER  = 3;
	// model selected by the stream type
	typedef enum logic [2:0] {
		MODE_IDLE  = 3'b001,
		MODE_SYNC  = 3'b010,
		MODE_SYNCD = 3'b100
	} sdd_mode_type;
	// byte class tagged by the demultiplexer
	typedef enum logic [2:0] {
		KIND_OTHER    = 3'h0,
		KIND_PES_HDR  = 3'h1,
		KIND_PKT_HDR  = 3'h2,
		KIND_PES_DATA = 3'h3,
		KIND_SEC_HDR  = 3'h4,
		KIND_SEC_DATA = 3'h5,
		KIND_SEC_CRC  = 3'h6,
		KIND_DL_HDR   = 3'h7
	} sdd_kind_type;
endpackage

// File: inc/sdd_mem_if.sv
`timescale 1ns/1ns
interface sdd_mem_if;
	logic                          we;
	logic [sdd_pkg::SB_AW-1:0]     waddr;
	logic [sdd_pkg::MEM_W-1:0]     wdata;
	logic [sdd_pkg::SB_AW-1:0]     raddr;
	logic [sdd_pkg::MEM_W-1:0]     rdata;
	modport ctrl (output we, waddr, wdata, raddr, input rdata);
	modport mem (input we, waddr, wdata, raddr, output rdata);
endinterface

// File: hw/sdd_byte_mem.sv
`timescale 1ns/1ns
module sdd_byte_mem
(
	input wire logic i_clk_sys, // system clock
	sdd_mem_if.mem   port       // write and registered read port
);
	logic [sdd_pkg::MEM_W-1:0] mem_r [0:sdd_pkg::SB_DEPTH-1];

	// write port
	always_ff @(posedge i_clk_sys)
	begin
		if (port.we)
			mem_r[port.waddr] <= port.wdata;
	end

	// registered read, old data on a same-address write
	always_ff @(posedge i_clk_sys)
	begin
		port.rdata <= mem_r[port.raddr];
	end
endmodule

// File: hw/sdd_decoder_top.sv
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
module sdd_decoder_top
(
	input  wire logic        i_clk_sys,      // 20 MHz system clock
	input  wire logic        i_rst_n,        // synchronous reset, active low
	input  wire logic [7:0]  i_addr,         // register byte address
	input  wire logic [31:0] i_wdata,        // register write data
	input  wire logic        i_wr,           // register write strobe
	input  wire logic        i_rd,           // register read strobe
	output logic      [31:0] o_rdata,        // read data, cycle after i_rd
	input  wire logic        i_byte_valid,   // transport byte present
	input  wire logic [7:0]  i_byte,         // transport byte
	input  wire logic [2:0]  i_kind,         // byte class
	input  wire logic        i_dup,          // byte of a duplicate packet
	input  wire logic        i_hdr_valid,    // header parsed, pulse
	input  wire logic        i_hdr_sec,      // header is a section header
	input  wire logic        i_hdr_pts_ok,   // header carries a stamp
	input  wire logic [32:0] i_hdr_pts,      // presentation stamp
	input  wire logic        i_hdr_sec_zero, // section number is zero
	input  wire logic [20:0] i_hdr_key,      // module extension and version
	input  wire logic [7:0]  i_hdr_table_id, // section table id
	input  wire logic [15:0] i_hdr_incr_cyc, // unit period from increment
	input  wire logic [15:0] i_hdr_es_cyc,   // unit period from ES rate
	input  wire logic [32:0] i_stc,          // recovered system time clock
	output logic             o_unit_valid,   // 16-bit unit pulse
	output logic      [15:0] o_unit_data,    // 16-bit unit, first byte high
	output logic             o_dau_valid,    // access unit removal pulse
	output logic      [16:0] o_dau_len,      // bytes of that access unit
	output logic             o_err           // any sticky error
);
	// model choice from the stream type
	function automatic sdd_pkg::sdd_mode_type mode_of(input logic [7:0] st);
		if (st == sdd_pkg::ST_SYNC)
			mode_of = sdd_pkg::MODE_SYNC;
		else if (st == sdd_pkg::ST_SYNCD_A || st == sdd_pkg::ST_SYNCD_B)
			mode_of = sdd_pkg::MODE_SYNCD;
		else
			mode_of = sdd_pkg::MODE_IDLE;
	endfunction

	// timeline has reached a stamp
	function automatic logic reached(input logic [32:0] stc, input logic [32:0] pts);
		reached = (stc >= pts);
	endfunction

	// es rate period serves fast streams, increment period the slow ones
	function automatic logic [15:0] sel_period(input logic [15:0] incr, input logic [15:0] es);
		sel_period = (es != 16'h0000 && es <= sdd_pkg::SPLIT_CYC) ? es : incr;
	endfunction

	logic [8:0]                 ctrl_r;
	logic [15:0]                leak_r;
	logic [13:0]                sbsize_r;
	logic [3:0]                 err_r;
	logic [3:0]                 err_set;
	logic [3:0]                 err_nxt;
	sdd_pkg::sdd_mode_type      mode;
	logic [9:0]                 tb_cnt_r;
	logic                       start_pend_r;
	logic [20:0]                key_r;
	logic                       key_ok_r;
	logic                       tid_ok_r;
	logic [2:0]                 skip_r;
	logic [15:0]                unit_per_r;
	logic [32:0]                pts_r [0:3];
	logic [16:0]                len_r [0:3];
	logic [2:0]                 wr_p;
	logic [2:0]                 arr_p;
	logic [2:0]                 rm_p;
	logic [13:0]                sb_wa_r;
	logic [13:0]                sb_ra_r;
	logic [13:0]                sb_cnt_r;
	logic                       wr_d1_r;
	logic [15:0]                pace_r;
	logic                       half_r;
	logic [7:0]                 lo_r;
	logic [16:0]                deb_cnt_r;
	logic [16:0]                deb_cnt_nxt;
	logic [16:0]                cur_len_r;
	logic                       admit;
	logic                       keep;
	logic                       sb_we;
	logic [13:0]                sb_cap;
	logic                       ring_full;
	logic                       stamp_push;
	logic                       head_ok;
	logic                       head_keep;
	logic                       head_start;
	logic                       skip_pop;
	logic                       byte_go;
	logic                       pop;
	logic                       rem_go;
	logic                       under;
	logic [15:0]                period;
	logic [2:0]                 units;

	sdd_mem_if sb_port ();

	// smoothing stage buffer storage
	sdd_byte_mem u_sb_mem
	(
		.i_clk_sys (i_clk_sys),
		.port      (sb_port.mem)
	);

	always_comb mode = mode_of(ctrl_r[7:0]); // see RULE_03 see RULE_13

	// ingress filter into the smoothing stage buffer
	assign admit = i_byte_valid && !i_dup && i_kind != sdd_pkg::KIND_OTHER // see RULE_05
		&& (mode == sdd_pkg::MODE_SYNCD // see RULE_14
		|| (mode == sdd_pkg::MODE_SYNC && i_kind <= sdd_pkg::KIND_PES_DATA)); // see RULE_04
	assign keep = (i_kind == sdd_pkg::KIND_PES_DATA) // see RULE_18
		|| (mode == sdd_pkg::MODE_SYNCD && i_kind == sdd_pkg::KIND_SEC_DATA
		&& tid_ok_r && key_ok_r && skip_r == 3'h0); // see RULE_19 see RULE_20
	assign sb_cap = ctrl_r[sdd_pkg::CTRL_DESC] ? sbsize_r : sdd_pkg::SB_BYTES; // see RULE_25
	assign sb_we = admit && (sb_cnt_r < sb_cap);
	assign units = 3'(wr_p - rm_p);
	assign ring_full = (units == 3'h4);
	assign stamp_push = i_hdr_valid && i_hdr_pts_ok && (!i_hdr_sec || i_hdr_sec_zero)
		&& mode != sdd_pkg::MODE_IDLE && !ring_full; // see RULE_15 see RULE_16

	// memory port, read address looks one entry ahead on a pop
	assign sb_port.we = sb_we;
	assign sb_port.waddr = sb_wa_r;
	assign sb_port.wdata = {start_pend_r && keep, keep, i_byte};
	assign sb_port.raddr = pop ? 14'(sb_ra_r + 14'h0001) : sb_ra_r;

	// head of the smoothing stage buffer; a word written last cycle is not yet readable
	assign head_ok = sb_cnt_r > {13'h0000, wr_d1_r};
	assign head_keep = sb_port.rdata[sdd_pkg::BIT_KEEP];
	assign head_start = sb_port.rdata[sdd_pkg::BIT_START];
	assign skip_pop = head_ok && !head_keep; // see RULE_09
	assign period = (mode == sdd_pkg::MODE_SYNC) ? unit_per_r
		: (ctrl_r[sdd_pkg::CTRL_DESC] ? leak_r : sdd_pkg::LEAK_CYC_DEF); // see RULE_10 see RULE_25

	// drain decision for payload bytes
	always_comb
	begin
		byte_go = 1'b0;
		if (head_ok && head_keep && mode == sdd_pkg::MODE_SYNC)
			byte_go = half_r || (pace_r == 16'h0000 && (!head_start // see RULE_08
				|| reached(i_stc, pts_r[rm_p[1:0]]))); // see RULE_07 see RULE_12
		else if (head_ok && head_keep && mode == sdd_pkg::MODE_SYNCD)
			byte_go = pace_r == 16'h0000 && deb_cnt_r < sdd_pkg::DEB_BYTES; // see RULE_21 see RULE_22
	end
	assign pop = skip_pop || byte_go;

	// unit removal and underflow at the stamp
	assign rem_go = mode == sdd_pkg::MODE_SYNCD && 3'(arr_p - rm_p) >= 3'h2
		&& reached(i_stc, pts_r[rm_p[1:0]]); // see RULE_26
	assign under = mode == sdd_pkg::MODE_SYNCD && units != 3'h0 && 3'(arr_p - rm_p) < 3'h2
		&& reached(i_stc, pts_r[rm_p[1:0]]) && !(byte_go && head_start);

	// reassembly occupancy after arrival and removal
	always_comb
	begin
		deb_cnt_nxt = deb_cnt_r;
		if (byte_go && mode == sdd_pkg::MODE_SYNCD)
			deb_cnt_nxt = 17'(deb_cnt_nxt + 17'h0_0001);
		if (rem_go)
			deb_cnt_nxt = 17'(deb_cnt_nxt - len_r[rm_p[1:0]]);
	end

	// error sources, set wins over a software clear
	always_comb
	begin
		err_set = 4'h0;
		err_set[sdd_pkg::ERR_TB] = i_byte_valid && tb_cnt_r == sdd_pkg::TB_BYTES; // see RULE_28
		err_set[sdd_pkg::ERR_SB] = admit && !sb_we; // see RULE_28
		err_set[sdd_pkg::ERR_RING] = i_hdr_valid && i_hdr_pts_ok && ring_full; // see RULE_28
		err_set[sdd_pkg::ERR_UNDER] = under; // see RULE_28
		err_nxt = err_r;
		if (i_wr && i_addr == sdd_pkg::REG_STATUS)
			err_nxt = err_r & ~i_wdata[3:0];
		err_nxt = err_nxt | err_set;
	end

	// software-written control
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_n)
		begin
			ctrl_r <= sdd_pkg::CTRL_RST;
			leak_r <= sdd_pkg::LEAK_CYC_DEF;
			sbsize_r <= sdd_pkg::SB_BYTES;
		end
		else if (i_wr)
		begin
			if (i_addr == sdd_pkg::REG_CTRL)
				ctrl_r <= i_wdata[8:0];
			else if (i_addr == sdd_pkg::REG_LEAK)
				leak_r <= i_wdata[15:0];
			else if (i_addr == sdd_pkg::REG_SBSIZE)
				sbsize_r <= i_wdata[13:0];
		end
	end

	// read data, valid only in the cycle after the strobe
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_n || !i_rd)
			o_rdata <= 32'h0000_0000;
		else if (i_addr == sdd_pkg::REG_CTRL)
			o_rdata <= {23'h00_0000, ctrl_r};
		else if (i_addr == sdd_pkg::REG_LEAK)
			o_rdata <= {16'h0000, leak_r};
		else if (i_addr == sdd_pkg::REG_SBSIZE)
			o_rdata <= {18'h0_0000, sbsize_r};
		else if (i_addr == sdd_pkg::REG_STATUS)
			o_rdata <= {28'h000_0000, err_r};
		else if (i_addr == sdd_pkg::REG_DEBOCC)
			o_rdata <= {15'h0000, deb_cnt_r};
		else
			o_rdata <= 32'h0000_0000;
	end

	// sticky errors
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_n)
		begin
			err_r <= 4'h0;
			o_err <= 1'b0;
		end
		else
		begin
			err_r <= err_nxt;
			o_err <= |err_nxt;
		end
	end

	// transport stage occupancy, emptied one byte per cycle in which no byte arrives
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_n)
			tb_cnt_r <= 10'h000;
		else if (i_byte_valid && tb_cnt_r != sdd_pkg::TB_BYTES)
			tb_cnt_r <= 10'(tb_cnt_r + 10'h001); // see RULE_24
		else if (!i_byte_valid && tb_cnt_r != 10'h000)
			tb_cnt_r <= 10'(tb_cnt_r - 10'h001);
	end

	// header state: stamps, section module match, block prefix skip
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_n)
		begin
			start_pend_r <= 1'b0;
			key_r <= 21'h00_0000;
			key_ok_r <= 1'b0;
			tid_ok_r <= 1'b0;
			skip_r <= 3'h0;
			wr_p <= 3'h0;
			unit_per_r <= sdd_pkg::LEAK_CYC_DEF;
		end
		else if (i_hdr_valid)
		begin
			start_pend_r <= stamp_push; // see RULE_15
			if (stamp_push)
				wr_p <= 3'(wr_p + 3'h1);
			if (i_hdr_sec)
			begin
				tid_ok_r <= i_hdr_table_id == sdd_pkg::TID_DL; // see RULE_19
				skip_r <= sdd_pkg::BLK_SKIP; // see RULE_20
				if (i_hdr_pts_ok && i_hdr_sec_zero)
					key_r <= i_hdr_key;
				key_ok_r <= (i_hdr_pts_ok && i_hdr_sec_zero)
					|| (key_ok_r && i_hdr_key == key_r); // see RULE_16
			end
			else
				unit_per_r <= sel_period(i_hdr_incr_cyc, i_hdr_es_cyc); // see RULE_08 see RULE_10
		end
		else
		begin
			if (sb_we && keep)
				start_pend_r <= 1'b0;
			if (sb_we && i_kind == sdd_pkg::KIND_SEC_DATA && skip_r != 3'h0)
				skip_r <= 3'(skip_r - 3'h1);
		end
	end

	// stamp ring contents
	always_ff @(posedge i_clk_sys)
	begin
		if (stamp_push)
			pts_r[wr_p[1:0]] <= i_hdr_pts;
	end

	// smoothing stage pointers and occupancy
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_n)
		begin
			sb_wa_r <= 14'h0000;
			sb_ra_r <= 14'h0000;
			sb_cnt_r <= 14'h0000;
			wr_d1_r <= 1'b0;
		end
		else
		begin
			wr_d1_r <= sb_we;
			if (sb_we)
				sb_wa_r <= 14'(sb_wa_r + 14'h0001);
			if (pop)
				sb_ra_r <= 14'(sb_ra_r + 14'h0001);
			sb_cnt_r <= 14'(sb_cnt_r + {13'h0000, sb_we} - {13'h0000, pop});
		end
	end

	// leak pacing
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_n)
			pace_r <= 16'h0000;
		else if (byte_go && (mode == sdd_pkg::MODE_SYNCD || half_r))
			pace_r <= (period == 16'h0000) ? 16'h0000 : 16'(period - 16'h0001); // see RULE_21
		else if (pace_r != 16'h0000)
			pace_r <= 16'(pace_r - 16'h0001);
	end

	// synchronous 16-bit unit output
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_n)
		begin
			half_r <= 1'b0;
			lo_r <= 8'h00;
			o_unit_valid <= 1'b0;
			o_unit_data <= 16'h0000;
		end
		else
		begin
			o_unit_valid <= 1'b0;
			if (byte_go && mode == sdd_pkg::MODE_SYNC)
			begin
				half_r <= !half_r;
				lo_r <= sb_port.rdata[7:0];
				if (half_r)
				begin
					o_unit_valid <= 1'b1; // see RULE_07
					o_unit_data <= {lo_r, sb_port.rdata[7:0]};
				end
			end
		end
	end

	// reassembly buffer: arrivals, unit lengths, removal at the stamp
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_n)
		begin
			arr_p <= 3'h0;
			rm_p <= 3'h0;
			deb_cnt_r <= 17'h0_0000;
			cur_len_r <= 17'h0_0000;
			o_dau_valid <= 1'b0;
			o_dau_len <= 17'h0_0000;
		end
		else
		begin
			deb_cnt_r <= deb_cnt_nxt; // see RULE_27
			o_dau_valid <= rem_go; // see RULE_26
			if (rem_go)
				o_dau_len <= len_r[rm_p[1:0]];
			if (rem_go || (byte_go && head_start && mode == sdd_pkg::MODE_SYNC))
				rm_p <= 3'(rm_p + 3'h1);
			if (byte_go && mode == sdd_pkg::MODE_SYNCD && head_start)
			begin
				arr_p <= 3'(arr_p + 3'h1); // see RULE_15 see RULE_16
				cur_len_r <= 17'h0_0001;
			end
			else if (byte_go && mode == sdd_pkg::MODE_SYNCD)
				cur_len_r <= 17'(cur_len_r + 17'h0_0001);
		end
	end

	// closed unit length, written when the next unit begins
	always_ff @(posedge i_clk_sys)
	begin
		if (byte_go && mode == sdd_pkg::MODE_SYNCD && head_start && arr_p != rm_p)
			len_r[2'(arr_p - 3'h1)] <= cur_len_r;
	end

	// checks
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_n);

	chk_dup_block: assert property (i_dup |-> !sb_port.we) // see RULE_05
		else $error("duplicate packet byte entered smoothing buffer");
	chk_sync_filter: assert property ( // see RULE_04
		mode == sdd_pkg::MODE_SYNC && i_kind >= sdd_pkg::KIND_SEC_HDR |-> !sb_port.we)
		else $error("non-PES byte admitted in synchronous mode");
	chk_idle_filter: assert property (mode == sdd_pkg::MODE_IDLE |-> !sb_port.we) // see RULE_13
		else $error("byte admitted for an unsupported stream type");
	chk_skip_fast: assert property (skip_pop |=> sb_ra_r == 14'($past(sb_ra_r) + 14'h0001)) // see RULE_09
		else $error("non-payload byte not dropped at once");
	chk_leak_gap: assert property ( // see RULE_25
		byte_go && mode == sdd_pkg::MODE_SYNCD && !ctrl_r[sdd_pkg::CTRL_DESC]
		&& !(i_wr && i_addr == sdd_pkg::REG_CTRL) |=> !byte_go [*8])
		else $error("default leak faster than one byte in nine cycles");
	chk_deb_stop: assert property ( // see RULE_22
		deb_cnt_r == sdd_pkg::DEB_BYTES && !rem_go |=> deb_cnt_r == $past(deb_cnt_r))
		else $error("smoothing buffer drained into a full reassembly buffer");
	chk_deb_bound: assert property (deb_cnt_r <= sdd_pkg::DEB_BYTES) // see RULE_27
		else $error("reassembly occupancy above capacity");
	chk_tb_bound: assert property (tb_cnt_r <= sdd_pkg::TB_BYTES) // see RULE_24
		else $error("transport stage occupancy above 512");
	chk_dau_time: assert property ( // see RULE_26
		rem_go |=> o_dau_valid && o_dau_len == $past(len_r[rm_p[1:0]]))
		else $error("access unit removal not reported");
	chk_under_flag: assert property (under |=> err_r[sdd_pkg::ERR_UNDER] && o_err) // see RULE_28
		else $error("late access unit not flagged");

	cov_unit_out: cover property (o_unit_valid ##[1:40] o_unit_valid);
	cov_dau_out: cover property (o_dau_valid);
	cov_deb_full: cover property (deb_cnt_r == sdd_pkg::DEB_BYTES);
endmodule

// File: testbench/sdd_demux_model.sv
`timescale 1ns/1ns
// demultiplexer side: classified byte stream, header pulses and time base
module sdd_demux_model
(
	input  wire logic        i_clk_sys,      // system clock
	output logic             o_byte_valid,   // byte present
	output logic      [7:0]  o_byte,         // byte
	output logic      [2:0]  o_kind,         // byte class
	output logic             o_dup,          // duplicate packet byte
	output logic             o_hdr_valid,    // header pulse
	output logic             o_hdr_pts_ok,   // header stamped
	output logic      [32:0] o_hdr_pts,      // stamp
	output logic      [15:0] o_hdr_incr_cyc, // unit period
	output logic      [32:0] o_stc           // system time clock
);
	initial
	begin
		o_byte_valid = 1'b0;
		o_byte = 8'h00;
		o_kind = 3'h0;
		o_dup = 1'b0;
		o_hdr_valid = 1'b0;
		o_hdr_pts_ok = 1'b0;
		o_hdr_pts = 33'h0_0000_0000;
		o_hdr_incr_cyc = 16'h0000;
		o_stc = 33'h0_0000_0000;
	end
	// free-running time base, one tick per clock cycle, keeps stamps on the timeline
	always @(posedge i_clk_sys)
		o_stc <= o_stc + 33'h0_0000_0001;
	// header pulse in a cycle of its own, never with a byte
	task automatic hdr(input logic s, input logic [32:0] p, input logic [15:0] inc);
		@(posedge i_clk_sys);
		o_hdr_valid <= 1'b1;
		o_hdr_pts_ok <= s;
		o_hdr_pts <= p;
		o_hdr_incr_cyc <= inc;
		o_byte_valid <= 1'b0;
	endtask
	// one byte a cycle; back-to-back calls give bursts of any length, with no rate ceiling
	task automatic put(input logic [2:0] k, input logic [7:0] d, input logic dp);
		@(posedge i_clk_sys);
		o_hdr_valid <= 1'b0;
		o_byte_valid <= 1'b1;
		o_kind <= k;
		o_byte <= d;
		o_dup <= dp;
	endtask
	// released byte lines show the inverse of the last value
	task automatic idle();
		@(posedge i_clk_sys);
		o_hdr_valid <= 1'b0;
		o_byte_valid <= 1'b0;
		o_byte <= ~o_byte;
	endtask
endmodule

// File: testbench/sdd_decoder_top_tb_top.sv
`timescale 1ns/1ns
module sdd_decoder_top_tb_top;
	logic        i_clk_sys, i_rst_n, i_wr, i_rd, bv, dup, hv, hs, hsec, hzero;
	logic [7:0]  i_addr, bt, htid;
	logic [31:0] i_wdata, o_rdata;
	logic [2:0]  kd;
	logic [32:0] hp, stc, pa;
	logic [20:0] hkey;
	logic [15:0] hi, o_unit_data, hes;
	logic        o_unit_valid, o_dau_valid, o_err;
	logic [16:0] o_dau_len;
	logic [7:0]  b [4];
	logic [15:0] u_data [$];
	logic [32:0] u_stc [$], d_stc [$];
	logic [16:0] d_len [$];
	int          u_cyc [$];
	int          errors, comparisons, cyc, seed;
	sdd_demux_model sdd_demux_model_i (.i_clk_sys(i_clk_sys), .o_byte_valid(bv), .o_byte(bt),
		.o_kind(kd), .o_dup(dup), .o_hdr_valid(hv), .o_hdr_pts_ok(hs), .o_hdr_pts(hp),
		.o_hdr_incr_cyc(hi), .o_stc(stc));
	sdd_decoder_top sdd_decoder_top_i (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_byte_valid(bv),
		.i_byte(bt), .i_kind(kd), .i_dup(dup), .i_hdr_valid(hv), .i_hdr_sec(hsec),
		.i_hdr_pts_ok(hs), .i_hdr_pts(hp), .i_hdr_sec_zero(hzero), .i_hdr_key(hkey),
		.i_hdr_table_id(htid), .i_hdr_incr_cyc(hi), .i_hdr_es_cyc(hes), .i_stc(stc),
		.o_unit_valid(o_unit_valid), .o_unit_data(o_unit_data), .o_dau_valid(o_dau_valid),
		.o_dau_len(o_dau_len), .o_err(o_err));
	// clock and time-zero values
	initial
	begin
		i_clk_sys = 1'b0;
		forever #25 i_clk_sys = ~i_clk_sys;
	end
	// collect output units with their cycle and time base
	always @(posedge i_clk_sys)
	begin
		cyc <= cyc + 1;
		if (o_unit_valid === 1'b1)
		begin
			u_data.push_back(o_unit_data);
			u_cyc.push_back(cyc);
			u_stc.push_back(stc);
		end
		if (o_dau_valid === 1'b1)
		begin
			d_len.push_back(o_dau_len);
			d_stc.push_back(stc);
		end
	end
	function automatic logic [15:0] unit(input logic [7:0] a, input logic [7:0] c);
		return {a, c};
	endfunction
	task automatic stop_test();
		if (errors == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [32:0] e, input logic [32:0] g);
		comparisons++;
		if (g !== e)
		begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rst();
		i_rst_n <= 1'b0;
		repeat (3) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		u_data.delete();
		u_cyc.delete();
		u_stc.delete();
		d_len.delete();
		d_stc.delete();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
		@(posedge i_clk_sys);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
		#1 chk(n, {1'b0, e}, {1'b0, o_rdata});
	endtask
	task automatic wait_for(input int n, input bit data_access_unit);
		for (int k = 0; k < 800 && (data_access_unit ? d_len.size() : u_data.size()) < n; k++)
			@(posedge i_clk_sys);
	endtask
	initial
	begin
		{i_rst_n, i_wr, i_rd, i_addr, i_wdata, hsec, hzero, hkey, htid, hes} = '0;
		errors = 0;
		comparisons = 0;
		seed = 58;
		rst();
		// reset values and an unmapped address
		rd(sdd_pkg::REG_CTRL, 32'h0000_0000, "ctrl");
		rd(sdd_pkg::REG_LEAK, 32'h0000_0009, "leak");
		rd(sdd_pkg::REG_SBSIZE, 32'h0000_2710, "sbsize");
		rd(sdd_pkg::REG_STATUS, 32'h0000_0000, "status");
		rd(8'h20, 32'h0000_0000, "unmapped");
		// synchronous: header, foreign and duplicate bytes, then stamped units
		wr(sdd_pkg::REG_CTRL, 32'h0000_00C2);
		pa = stc + 33'h0_0000_0064;
		hes <= 16'h0014;
		sdd_demux_model_i.hdr(1'b1, pa, 16'h0028);
		sdd_demux_model_i.put(sdd_pkg::KIND_PES_HDR, 8'($random(seed)), 1'b0);
		sdd_demux_model_i.put(sdd_pkg::KIND_OTHER, 8'($random(seed)), 1'b0);
		sdd_demux_model_i.put(sdd_pkg::KIND_PES_DATA, 8'($random(seed)), 1'b1);
		for (int i = 0; i < 4; i++)
		begin
			b[i] = 8'($random(seed));
			sdd_demux_model_i.put(sdd_pkg::KIND_PES_DATA, b[i], 1'b0);
		end
		sdd_demux_model_i.idle();
		wait_for(2, 1'b0);
		chk("unit count", 33'd2, 33'(u_data.size()));
		if (u_data.size() == 2)
		begin
			chk("unit one", 33'(unit(b[0], b[1])), 33'(u_data[0]));
			chk("unit two", 33'(unit(b[2], b[3])), 33'(u_data[1]));
			chk("unit time", 33'd1, 33'(u_stc[0] >= pa && u_stc[0] <= pa + 4));
			chk("unit gap", 33'd1, 33'(u_cyc[1] - u_cyc[0] inside {[20:24]}));
		end
		// synchronized PES: headers stripped, unit closed by the next stamp
		rst();
		wr(sdd_pkg::REG_CTRL, 32'h0000_0006);
		pa = stc + 33'h0_0000_012C;
		sdd_demux_model_i.hdr(1'b1, pa, 16'h0000);
		sdd_demux_model_i.put(sdd_pkg::KIND_PES_HDR, 8'($random(seed)), 1'b0);
		sdd_demux_model_i.put(sdd_pkg::KIND_PKT_HDR, 8'($random(seed)), 1'b0);
		for (int i = 0; i < 3; i++)
			sdd_demux_model_i.put(sdd_pkg::KIND_PES_DATA, 8'($random(seed)), 1'b0);
		sdd_demux_model_i.put(sdd_pkg::KIND_OTHER, 8'($random(seed)), 1'b0);
		sdd_demux_model_i.put(sdd_pkg::KIND_PES_DATA, 8'($random(seed)), 1'b1);
		sdd_demux_model_i.hdr(1'b1, pa + 33'h0_0000_07D0, 16'h0000);
		sdd_demux_model_i.put(sdd_pkg::KIND_PES_DATA, 8'($random(seed)), 1'b0);
		sdd_demux_model_i.idle();
		wait_for(1, 1'b1);
		chk("dau count", 33'd1, 33'(d_len.size()));
		if (d_len.size() == 1)
		begin
			chk("dau len", 33'd3, 33'(d_len[0]));
			chk("dau time", 33'd1, 33'(d_stc[0] >= pa && d_stc[0] <= pa + 4));
		end
		chk("err clear", 33'd0, 33'(o_err));
		// section download: filtered payload, stamped section 0 opens a unit
		rst();
		wr(sdd_pkg::REG_CTRL, 32'h0000_0014);
		pa = stc + 33'h0_0000_012C;
		{hsec, hzero, htid, hkey} <= {2'b11, sdd_pkg::TID_DL, 21'($random(seed))};
		for (int s = 0; s < 2; s++)
		begin
			sdd_demux_model_i.hdr(1'b1, pa + 33'(s) * 33'h0_0000_07D0, 16'h0000);
			sdd_demux_model_i.put(sdd_pkg::KIND_SEC_HDR, 8'($random(seed)), 1'b0);
			sdd_demux_model_i.put(sdd_pkg::KIND_DL_HDR, 8'($random(seed)), 1'b0);
			for (int i = 0; i < 9; i++)
				sdd_demux_model_i.put(sdd_pkg::KIND_SEC_DATA, 8'($random(seed)), 1'b0);
			sdd_demux_model_i.put(sdd_pkg::KIND_SEC_CRC, 8'($random(seed)), 1'b0);
		end
		sdd_demux_model_i.idle();
		wait_for(1, 1'b1);
		chk("sec count", 33'd1, 33'(d_len.size()));
		if (d_len.size() == 1)
			chk("sec len", 33'd3, 33'(d_len[0]));
		rd(sdd_pkg::REG_DEBOCC, 32'h0000_0003, "debocc");
		// transport and smoothing overflow with a small descriptor size, then clear
		rst();
		wr(sdd_pkg::REG_LEAK, 32'h0000_FFFF);
		wr(sdd_pkg::REG_SBSIZE, 32'h0000_0002);
		wr(sdd_pkg::REG_CTRL, 32'h0000_0106);
		rd(sdd_pkg::REG_CTRL, 32'h0000_0106, "ctrl");
		for (int i = 0; i < 514; i++)
			sdd_demux_model_i.put(sdd_pkg::KIND_PES_DATA, 8'($random(seed)), 1'b0);
		sdd_demux_model_i.idle();
		rd(sdd_pkg::REG_STATUS, 32'h0000_0003, "status");
		chk("err set", 33'd1, 33'(o_err));
		wr(sdd_pkg::REG_STATUS, 32'h0000_0003);
		rd(sdd_pkg::REG_STATUS, 32'h0000_0000, "status");
		chk("err cleared", 33'd0, 33'(o_err));
		stop_test();
	end
	// watchdog well beyond the thousand-odd cycles the run needs
	initial
	begin
		repeat (20000) @(posedge i_clk_sys);
		errors++;
		stop_test();
	end
endmodule
